// ==== rtl/fpw_pkg.sv ====
// Purpose: Shared constants for the fast PWM waveform generator.
// Assumes: 32-bit AHB-Lite register bus, one clock at 125 MHz.
// Notes:   Byte offsets, field positions, reset values and mode codes.
package fpw_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMPA   = 8'h04;
  localparam logic [7:0] OFS_CMPB   = 8'h08;
  localparam logic [7:0] OFS_COUNT  = 8'h0c;
  localparam logic [7:0] OFS_DIR    = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_CLEAR  = 8'h18;
  localparam logic [7:0] OFS_ENABLE = 8'h1c;

  // Control register field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_OMA_LSB   = 4;
  localparam int CTRL_OMB_LSB   = 6;
  localparam int CTRL_CSEL_LSB  = 8;

  // Status, clear and enable bit positions
  localparam int ST_OVF    = 0;
  localparam int ST_MATCHA = 1;
  localparam int ST_MATCHB = 2;
  localparam int ST_W      = 3;

  // Reset values
  localparam logic [2:0]  RST_MODE = 3'h0;
  localparam logic [1:0]  RST_OM   = 2'h0;
  localparam logic [2:0]  RST_CSEL = 3'h0;
  localparam logic [7:0]  RST_CMP  = 8'h00;
  localparam logic [1:0]  RST_DIR  = 2'h0;
  localparam logic [ST_W-1:0] RST_ST = 3'h0;

  // Waveform mode codes
  localparam logic [2:0] MODE_FAST_FIXED = 3'h3;
  localparam logic [2:0] MODE_FAST_CMPA  = 3'h7;

  // Count limits
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;

  // Compare output modes
  localparam logic [1:0] OM_OFF    = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_NONINV = 2'h2;
  localparam logic [1:0] OM_INV    = 2'h3;

  // Prescale selections and divide counts
  localparam logic [2:0] CSEL_STOP  = 3'h0;
  localparam logic [2:0] CSEL_DIV1  = 3'h1;
  localparam logic [2:0] CSEL_DIV8  = 3'h2;
  localparam logic [2:0] CSEL_DIV64 = 3'h3;
  localparam logic [2:0] CSEL_DIV256  = 3'h4;
  localparam logic [2:0] CSEL_DIV1024 = 3'h5;
  localparam logic [9:0] DIV_8    = 10'h007;
  localparam logic [9:0] DIV_64   = 10'h03f;
  localparam logic [9:0] DIV_256  = 10'h0ff;
  localparam logic [9:0] DIV_1024 = 10'h3ff;

endpackage

// ==== rtl/fpw_tick_if.sv ====
// Purpose: Carries the prescale choice and the timer tick.
// Assumes: Both ends share hclk.
// Notes:   Tick is an enable, high for one hclk cycle per timer clock.
`timescale 1ns/100ps
`default_nettype none
interface fpw_tick_if;
  logic [2:0] clk_sel;
  logic       tick;
  modport prescaler (input clk_sel, output tick);
  modport timer     (output clk_sel, input tick);
endinterface
`default_nettype wire

// ==== rtl/fpw_prescaler.sv ====
// Purpose: Divides hclk into the timer tick: 1, 8, 64, 256 or 1024.
// Assumes: Selection comes from a register on hclk.
// Notes:   Stop selection holds the divider at zero and freezes the timer.
`timescale 1ns/100ps
`default_nettype none
module fpw_prescaler (
  // Clock and reset
  input wire logic      hclk,
  input wire logic      hresetn,
  // Tick link
  fpw_tick_if.prescaler tk
);
  import fpw_pkg::*;

  logic [9:0] div_cnt;
  logic [9:0] div_last;

  // Terminal count for the chosen factor
  always_comb begin
    case (tk.clk_sel)
      CSEL_DIV8:    div_last = DIV_8;
      CSEL_DIV64:   div_last = DIV_64;
      CSEL_DIV256:  div_last = DIV_256;
      CSEL_DIV1024: div_last = DIV_1024;
      default:      div_last = 10'h000;
    endcase
  end

  // Free divider; restarts whenever the factor is reached
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 10'h000;
    end else if (tk.clk_sel == CSEL_STOP || div_cnt >= div_last) begin
      div_cnt <= 10'h000;
    end else begin
      div_cnt <= div_cnt + 10'h001;
    end
  end

  // Reserved selections above 1024 behave as stopped
  assign tk.tick = (tk.clk_sel != CSEL_STOP) && (tk.clk_sel <= CSEL_DIV1024)
                   && (div_cnt >= div_last);

  // Divide by 8 spaces ticks eight clocks apart
  chk_div8_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    (tk.tick && tk.clk_sel == CSEL_DIV8) ##1 (tk.clk_sel == CSEL_DIV8) [*8]
    |-> tk.tick && !$past(tk.tick))
    else $error("divide by 8 tick spacing wrong");

endmodule
`default_nettype wire

// ==== rtl/fpw_timer.sv ====
// Purpose: Fast PWM waveform generator with an 8-bit counter, two channels.
// Assumes: AHB-Lite slave, single word transfers, hclk at 125 MHz.
// Notes:   Reads take one wait state; writes take none.
// How it works
// - Fast PWM runs when the waveform mode field is 3 or 7.
// - Counter counts up from BOTTOM to TOP, then restarts at BOTTOM.
// - TOP is 0xFF in mode 3, compare value A in mode 7.
// - Counter increments until TOP, clears at the next timer clock.
// - Non-inverting: output clears on compare match, sets at BOTTOM.
// - Inverting: output sets on compare match, clears at BOTTOM.
// - BOTTOM set or clear happens on the TOP to BOTTOM tick.
// - Output mode two selects non-inverted PWM, three inverted PWM.
// - Mode one toggles output A on match only with mode MSB set; never B.
// - The pin shows the waveform only when its direction is output.
// - Overflow flag sets at TOP in fast PWM; enabled flag raises interrupt.
// - Period is 256 timer clocks in mode 3, compare A plus one in mode 7; prescale 1, 8, 64, 256 or 1024.
// - In mode 3, compare A at BOTTOM gives one-clock pulse each MAX+1 clocks.
// - Compare A at MAX holds the output constantly high or low.
`timescale 1ns/100ps
`default_nettype none
module fpw_timer (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Waveform pins
  output logic             waveform_out_a,
  output logic             waveform_oe_a,
  output logic             waveform_out_b,
  output logic             waveform_oe_b,
  // Interrupt
  output logic             irq
);
  import fpw_pkg::*;

  fpw_tick_if tk ();

  // Registers
  logic [2:0]      waveform_mode_field;
  logic [1:0]      output_mode_a;
  logic [1:0]      output_mode_b;
  logic [2:0]      clk_sel;
  logic [7:0]      compare_value_a;
  logic [7:0]      compare_value_b;
  logic [1:0]      pin_dir;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] int_enable;
  logic [7:0]      timer_count_value;

  // Bus tracking
  logic            wr_pend;
  logic            rd_pend;
  logic [7:0]      addr_q;
  logic            accept;

  // Timer decode
  logic            fast_mode;
  logic            waveform_mode_msb;
  logic [7:0]      top_val;
  logic            at_top;
  logic            match_a;
  logic            match_b;
  logic [7:0]      next_count;
  logic [ST_W-1:0] events;
  logic [ST_W-1:0] clr_mask;

  fpw_prescaler u_presc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tk      (tk.prescaler)
  );

  assign tk.clk_sel = clk_sel;

  // Next level of a channel output on one timer tick
  function automatic logic next_wave(input logic [1:0] om, input logic cur,
                                     input logic top, input logic hit,
                                     input logic tgl_ok);
    logic r;
    r = cur;
    case (om)
      OM_NONINV: begin
        if (top) r = 1'b1;
        else if (hit) r = 1'b0;
      end
      OM_INV: begin
        if (top) r = 1'b0;
        else if (hit) r = 1'b1;
      end
      OM_TOGGLE: begin
        if (hit && tgl_ok) r = ~cur;
      end
      default: r = cur;
    endcase
    return r;
  endfunction

  // Whether a channel drives its pin in the current mode
  function automatic logic chan_on(input logic [1:0] om, input logic tgl_ok);
    return (om == OM_NONINV) || (om == OM_INV) || (om == OM_TOGGLE && tgl_ok);
  endfunction

  // Mode decode; only modes 3 and 7 run fast PWM
  assign fast_mode = (waveform_mode_field == MODE_FAST_FIXED)
                   || (waveform_mode_field == MODE_FAST_CMPA);
  assign waveform_mode_msb = waveform_mode_field[2];
  assign top_val = (waveform_mode_field == MODE_FAST_CMPA) ? compare_value_a
                                                           : CNT_MAX;
  assign at_top  = (timer_count_value == top_val);
  assign match_a = tk.tick && (timer_count_value == compare_value_a);
  assign match_b = tk.tick && (timer_count_value == compare_value_b);

  // Single slope: up to TOP, then BOTTOM on the next tick
  always_comb begin
    next_count = timer_count_value;
    if (tk.tick) begin
      if (at_top) next_count = CNT_BOTTOM;
      else next_count = timer_count_value + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_count_value <= CNT_BOTTOM;
    end else begin
      timer_count_value <= next_count;
    end
  end

  // Outputs update on every timer tick in fast PWM; BOTTOM wins over a
  // match at TOP, which keeps compare A at MAX a steady level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      waveform_out_a <= 1'b0;
      waveform_out_b <= 1'b0;
    end else if (tk.tick && fast_mode) begin
      waveform_out_a <= next_wave(output_mode_a, waveform_out_a, at_top,
                                  match_a, waveform_mode_msb);
      waveform_out_b <= next_wave(output_mode_b, waveform_out_b, at_top,
                                  match_b, 1'b0);
    end
  end

  // Pin drive needs fast PWM, a live channel and output direction
  assign waveform_oe_a = pin_dir[0] && fast_mode
                         && chan_on(output_mode_a, waveform_mode_msb);
  assign waveform_oe_b = pin_dir[1] && fast_mode
                         && chan_on(output_mode_b, 1'b0);

  // Events; overflow only counts in fast PWM
  assign events[ST_OVF]    = tk.tick && at_top && fast_mode;
  assign events[ST_MATCHA] = match_a;
  assign events[ST_MATCHB] = match_b;

  // Bus address phase
  assign accept = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= 8'h00;
    end else begin
      wr_pend <= accept && hwrite;
      rd_pend <= accept && !hwrite;
      if (accept) addr_q <= haddr[7:0];
    end
  end

  // Reads wait one cycle so a write just before is already stored
  assign hreadyout = !rd_pend;
  assign hresp     = 1'b0;

  // Read data captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend) begin
      case (addr_q)
        OFS_CTRL:   hrdata <= {21'h0, clk_sel, output_mode_b, output_mode_a,
                               1'b0, waveform_mode_field};
        OFS_CMPA:   hrdata <= {24'h0, compare_value_a};
        OFS_CMPB:   hrdata <= {24'h0, compare_value_b};
        OFS_COUNT:  hrdata <= {24'h0, timer_count_value};
        OFS_DIR:    hrdata <= {30'h0, pin_dir};
        OFS_STATUS: hrdata <= {29'h0, status};
        OFS_ENABLE: hrdata <= {29'h0, int_enable};
        default:    hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      waveform_mode_field <= RST_MODE;
      output_mode_a       <= RST_OM;
      output_mode_b       <= RST_OM;
      clk_sel             <= RST_CSEL;
      compare_value_a     <= RST_CMP;
      compare_value_b     <= RST_CMP;
      pin_dir             <= RST_DIR;
      int_enable          <= RST_ST;
    end else if (wr_pend) begin
      case (addr_q)
        OFS_CTRL: begin
          waveform_mode_field <= hwdata[CTRL_MODE_LSB +: 3];
          output_mode_a       <= hwdata[CTRL_OMA_LSB +: 2];
          output_mode_b       <= hwdata[CTRL_OMB_LSB +: 2];
          clk_sel             <= hwdata[CTRL_CSEL_LSB +: 3];
        end
        OFS_CMPA:   compare_value_a <= hwdata[7:0];
        OFS_CMPB:   compare_value_b <= hwdata[7:0];
        OFS_DIR:    pin_dir         <= hwdata[1:0];
        OFS_ENABLE: int_enable      <= hwdata[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  assign clr_mask = (wr_pend && addr_q == OFS_CLEAR) ? hwdata[ST_W-1:0] : RST_ST;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= RST_ST;
    end else begin
      status <= (status & ~clr_mask) | events;
    end
  end

  // Level interrupt while any enabled flag stands
  assign irq = |(status & int_enable);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_top_wrap: assert property (tk.tick && at_top |=> timer_count_value == CNT_BOTTOM)
    else $error("counter did not clear after TOP");

  chk_count_up: assert property (tk.tick && !at_top
    |=> timer_count_value == $past(timer_count_value) + 8'h01)
    else $error("counter did not increment");

  chk_top_select: assert property (waveform_mode_field == MODE_FAST_CMPA && tk.tick
    && timer_count_value == compare_value_a |=> timer_count_value == CNT_BOTTOM)
    else $error("compare A not used as TOP");

  chk_bottom_set: assert property (fast_mode && tk.tick && at_top
    && output_mode_a == OM_NONINV |=> waveform_out_a)
    else $error("non-inverted output not set at BOTTOM");

  chk_match_clear: assert property (fast_mode && match_a && !at_top
    && output_mode_a == OM_NONINV |=> !waveform_out_a)
    else $error("non-inverted output not cleared on match");

  chk_inv_bottom: assert property (fast_mode && tk.tick && at_top
    && output_mode_b == OM_INV |=> !waveform_out_b)
    else $error("inverted output not cleared at BOTTOM");

  chk_pin_gate: assert property (!pin_dir[0] |-> !waveform_oe_a)
    else $error("pin driven without output direction");

  chk_b_no_toggle: assert property (output_mode_b == OM_TOGGLE |-> !waveform_oe_b)
    else $error("channel B toggle mode drives the pin");

  chk_ovf_flag: assert property (fast_mode && tk.tick && at_top |=> status[ST_OVF])
    else $error("overflow flag not set at TOP");

  chk_mode_gate: assert property (!fast_mode ##1 !fast_mode |-> $stable(waveform_out_a))
    else $error("waveform moved outside fast PWM");

  chk_narrow_spike: assert property (fast_mode && output_mode_a == OM_NONINV
    && compare_value_a == CNT_BOTTOM && waveform_mode_field == MODE_FAST_FIXED
    && tk.tick && at_top |=> waveform_out_a)
    else $error("narrow pulse missing at BOTTOM");

  // Compare A at MAX in mode 3: once at its level, output A never moves
  chk_max_steady: assert property (fast_mode && waveform_mode_field == MODE_FAST_FIXED
    && compare_value_a == CNT_MAX
    && ((output_mode_a == OM_NONINV && waveform_out_a)
        || (output_mode_a == OM_INV && !waveform_out_a))
    |=> $stable(waveform_out_a))
    else $error("output A moved with compare A at MAX");

  // Main scenarios seen at least once
  cov_overflow: cover property (events[ST_OVF]);
  cov_toggle_a: cover property (output_mode_a == OM_TOGGLE && waveform_mode_msb && match_a);
  cov_irq:      cover property ($rose(irq));
  cov_narrow:   cover property (fast_mode && compare_value_a == CNT_BOTTOM && match_a);

endmodule
`default_nettype wire

// ==== sim/test_fast_pwm_waveform_generator.sv ====
// Purpose: Self-checking bench for the fast PWM waveform generator.
// Assumes: One AHB-Lite master in the bench, hclk at 125 MHz.
// Notes:   Pulse widths and periods are counted in hclk cycles.
`timescale 1ns/100ps
`default_nettype none
module test_fast_pwm_waveform_generator;
  import fpw_pkg::*;

  // Clock, reset and bus
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  // Pins and interrupt
  logic        waveform_out_a;
  logic        waveform_oe_a;
  logic        waveform_out_b;
  logic        waveform_oe_b;
  logic        irq;
  // Bookkeeping
  int          n_fail = 0;
  int          n_compared = 0;
  int          cycles = 0;

  fpw_timer DUT (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .hsel           (hsel),
    .haddr          (haddr),
    .htrans         (htrans),
    .hwrite         (hwrite),
    .hsize          (3'h2),
    .hwdata         (hwdata),
    .hready         (hreadyout),
    .hreadyout      (hreadyout),
    .hrdata         (hrdata),
    .hresp          (hresp),
    .waveform_out_a (waveform_out_a),
    .waveform_oe_a  (waveform_oe_a),
    .waveform_out_b (waveform_out_b),
    .waveform_oe_b  (waveform_oe_b),
    .irq            (irq)
  );

  // Free-running clock, 8 ns period
  always #4 hclk = ~hclk;

  // Hang guard, well above the longest prescaled measurement
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single-word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h00000000, rd);
    chk(rd, exp);
  endtask

  function automatic logic [31:0] ctrl(input logic [2:0] m, input logic [1:0] oa,
                                       input logic [1:0] ob, input logic [2:0] cs);
    return (32'(m) << CTRL_MODE_LSB) | (32'(oa) << CTRL_OMA_LSB) |
           (32'(ob) << CTRL_OMB_LSB) | (32'(cs) << CTRL_CSEL_LSB);
  endfunction

  function automatic logic pin(input logic b);
    return b ? waveform_out_b : waveform_out_a;
  endfunction

  // Time at level pol and full period, from a transition into pol
  task automatic measure(input logic b, input logic pol, input int exp_hi, input int exp_per);
    int hi;
    int per;
    while (pin(b) === pol) @(posedge hclk);
    while (pin(b) !== pol) @(posedge hclk);
    hi = 0;
    while (pin(b) === pol) begin
      hi++;
      @(posedge hclk);
    end
    per = hi;
    while (pin(b) !== pol) begin
      per++;
      @(posedge hclk);
    end
    chk(hi, exp_hi);
    chk(per, exp_per);
  endtask

  // Any glitch over n cycles is reported once
  task automatic steady(input logic b, input logic exp, input int n);
    logic got;
    got = exp;
    repeat (n) begin
      @(posedge hclk);
      if (pin(b) !== exp) got = pin(b);
    end
    chk(got, exp);
  endtask

  task automatic t_reset();
    chk({hresp, waveform_out_a, waveform_oe_a, waveform_out_b, waveform_oe_b, irq}, 0);
    rdc(OFS_CTRL, 32'h00000000);
    rdc(OFS_CMPA, 32'h00000000);
    rdc(OFS_DIR, 32'h00000000);
    rdc(OFS_STATUS, 32'h00000000);
    rdc(OFS_COUNT, 32'h00000000);
    wr(8'h40, 32'hffffffff);
    rdc(8'h40, 32'h00000000);
  endtask

  task automatic t_modes();
    wr(OFS_DIR, 32'h00000003);
    wr(OFS_CMPA, 32'h00000080);
    rdc(OFS_CMPA, 32'h00000080);
    for (int m = 0; m < 8; m++) begin
      wr(OFS_CTRL, ctrl(3'(m), OM_NONINV, OM_NONINV, CSEL_DIV1));
      repeat (2) @(posedge hclk);
      chk(waveform_oe_a, (m == 3 || m == 7));
    end
    wr(OFS_DIR, 32'h00000002);
    wr(OFS_CTRL, ctrl(MODE_FAST_FIXED, OM_NONINV, OM_NONINV, CSEL_DIV1));
    @(posedge hclk); // New setting shows only after its landing edge
    chk({waveform_oe_a, waveform_oe_b}, 2'b01);
    wr(OFS_DIR, 32'h00000003);
  endtask

  task automatic t_fixed();
    wr(OFS_CMPA, 32'h00000040);
    wr(OFS_CMPB, 32'h00000080);
    wr(OFS_CTRL, ctrl(MODE_FAST_FIXED, OM_NONINV, OM_INV, CSEL_DIV1));
    measure(1'b0, 1'b1, 65, 256);
    measure(1'b1, 1'b0, 129, 256);
    wr(OFS_CMPA, 32'h00000000);
    measure(1'b0, 1'b1, 1, 256);
    wr(OFS_CMPA, 32'h000000ff);
    repeat (300) @(posedge hclk);
    steady(1'b0, 1'b1, 600);
    wr(OFS_CTRL, ctrl(MODE_FAST_FIXED, OM_INV, OM_INV, CSEL_DIV1));
    repeat (300) @(posedge hclk);
    steady(1'b0, 1'b0, 600);
  endtask

  task automatic t_top_a();
    wr(OFS_CMPA, 32'h0000003f);
    wr(OFS_CMPB, 32'h00000010);
    wr(OFS_CTRL, ctrl(MODE_FAST_CMPA, OM_TOGGLE, OM_NONINV, CSEL_DIV1));
    measure(1'b0, 1'b1, 64, 128);
    measure(1'b1, 1'b1, 17, 64);
    // Toggle without the mode MSB, and toggle on B, must stay off the pin
    wr(OFS_CTRL, ctrl(MODE_FAST_FIXED, OM_TOGGLE, OM_NONINV, CSEL_DIV1));
    @(posedge hclk); // New mode shows only after its landing edge
    chk(waveform_oe_a, 1'b0);
    steady(1'b0, waveform_out_a, 600);
    wr(OFS_CTRL, ctrl(MODE_FAST_CMPA, OM_NONINV, OM_TOGGLE, CSEL_DIV1));
    @(posedge hclk);
    chk(waveform_oe_b, 1'b0);
  endtask

  task automatic t_prescale();
    int n [5] = '{1, 8, 64, 256, 1024};
    wr(OFS_CMPA, 32'h00000003);
    wr(OFS_CMPB, 32'h00000001);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL, ctrl(MODE_FAST_CMPA, OM_NONINV, OM_NONINV, CSEL_DIV1 + 3'(i)));
      measure(1'b1, 1'b1, 2 * n[i], 4 * n[i]);
    end
  endtask

  task automatic t_irq();
    wr(OFS_CMPA, 32'h00000010);
    wr(OFS_ENABLE, 32'h00000001);
    wr(OFS_CTRL, ctrl(MODE_FAST_FIXED, OM_NONINV, OM_NONINV, CSEL_DIV1));
    repeat (300) @(posedge hclk);
    chk(irq, 1'b1);
    rdc(OFS_STATUS, 32'h00000007);
    // Stop the timer so no new event races the clear
    wr(OFS_CTRL, ctrl(MODE_FAST_FIXED, OM_NONINV, OM_NONINV, CSEL_STOP));
    wr(OFS_CLEAR, 32'h00000007);
    rdc(OFS_STATUS, 32'h00000000);
    chk(irq, 1'b0);
    wr(OFS_ENABLE, 32'h00000000);
    wr(OFS_CTRL, ctrl(MODE_FAST_FIXED, OM_NONINV, OM_NONINV, CSEL_DIV1));
    repeat (300) @(posedge hclk);
    rdc(OFS_STATUS, 32'h00000007);
    chk(irq, 1'b0);
    // A non-fast mode still matches but never flags overflow
    wr(OFS_CTRL, ctrl(3'h0, OM_NONINV, OM_NONINV, CSEL_DIV1));
    wr(OFS_CLEAR, 32'h00000007);
    repeat (600) @(posedge hclk);
    rdc(OFS_STATUS, 32'h00000006);
  endtask

  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h00000000;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h00000000;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_modes();
    t_fixed();
    t_top_a();
    t_prescale();
    t_irq();
    report_and_stop();
  end
endmodule
`default_nettype wire
